// *** hdl/serial_port0_control.v ***
// Purpose: control, status and shifters of the first serial port
// Assumes: single AHB-Lite slave, zero wait states, OKAY only
// Notes: async modes run sixteen sub-ticks per bit, sampling at the middle one
`include "serial_port0_defs.vh"
`default_nettype none
module serial_port0_control #(
  parameter RELOAD_WIDTH = 16
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire hready_i,
  input wire [31:0] hwdata_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  input wire rxd_i,
  output wire rxd_o,
  output wire rxd_oe_o,
  output wire txd_o,
  output wire irq_o
);
  localparam T_IDLE = 6'b000001;
  localparam T_START = 6'b000010;
  localparam T_DATA = 6'b000100;
  localparam T_NINTH = 6'b001000;
  localparam T_STOP = 6'b010000;
  localparam T_SHIFT0 = 6'b100000;
  localparam R_IDLE = 5'b00001;
  localparam R_START = 5'b00010;
  localparam R_DATA = 5'b00100;
  localparam R_STOP = 5'b01000;
  localparam R_SHIFT0 = 5'b10000;
  localparam [7:0] PC_RESET = `SP_RST_POWER_CTRL;

  reg [31:0] hrdata_reg;
  reg hreadyout_reg;
  reg hresp_reg;
  reg wr_pend_reg;
  reg [9:0] wr_idx_reg;
  reg mode_hi_reg, mode_lo_reg, filter_reg, ren_reg, tb8_reg, rb8_reg;
  reg ti_reg, ri_reg, fe_reg;
  reg baud_double_reg, fcs_reg;
  reg [1:0] gflags_reg;
  reg [2:0] irq_status_reg;
  reg [2:0] irq_mask_reg;
  reg [RELOAD_WIDTH-1:0] reload_reg;
  reg irq_reg;
  reg [3:0] presc_cnt_reg;
  reg [5:0] tx_state_reg;
  reg [3:0] tx_sub_reg;
  reg [2:0] tx_bit_reg;
  reg tx_phase_reg;
  reg [7:0] tx_shift_reg;
  reg tx_ninth_reg;
  reg txd_reg, rxd_out_reg, rxd_oe_reg;
  reg [4:0] rx_state_reg;
  reg [3:0] rx_sub_reg;
  reg [3:0] rx_bit_reg;
  reg rx_phase_reg;
  reg [7:0] rx_shift_reg;
  reg rx_ninth_tmp_reg;
  reg [7:0] rx_buf_reg;
  reg rx_meta_reg, rx_sync_reg, rx_prev_reg;
  reg [3:0] lim;
  reg adv;
  reg [31:0] rd_word;
  reg rx_keep;
  reg rx_ninth_val;

  wire [1:0] mode = {mode_hi_reg, mode_lo_reg};
  wire ovf;
  wire bus_req = hsel_i && hready_i && htrans_i[1];
  wire addr_ok = (haddr_i[31:12] == 20'h0_0000);
  wire tick = adv && (presc_cnt_reg == (lim - 4'h1));
  wire tx_idle = (tx_state_reg == T_IDLE);
  wire rx_idle = (rx_state_reg == R_IDLE);

  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = hreadyout_reg;
  assign hresp_o = hresp_reg;
  assign rxd_o = rxd_out_reg;
  assign rxd_oe_o = rxd_oe_reg;
  assign txd_o = txd_reg;
  assign irq_o = irq_reg;

  baud_timer #(
    .WIDTH(RELOAD_WIDTH)
  ) u_baud_timer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .reload_i(reload_reg),
    .ovf_o(ovf)
  );

  // sub-tick divider: half bit in mode 0, sixteenth of a bit otherwise
  always @* begin
    lim = `SP_VAR_SUB_SLOW;
    adv = 1'b1;
    case (mode)
      2'b00: lim = filter_reg ? `SP_M0_HALF_FAST : `SP_M0_HALF_SLOW;
      2'b10: lim = baud_double_reg ? `SP_M2_SUB_FAST : `SP_M2_SUB_SLOW;
      default: begin
        lim = baud_double_reg ? `SP_VAR_SUB_FAST : `SP_VAR_SUB_SLOW;
        adv = ovf;
      end
    endcase
  end

  always @* begin
    rd_word = 32'h0000_0000;
    case (haddr_i[11:2])
      `SP_IDX_POWER_CTRL: rd_word[7:0] = {baud_double_reg, fcs_reg, 2'b00, gflags_reg, 2'b00};
      `SP_IDX_CTRL_STATUS: rd_word[7:0] = {(fcs_reg ? fe_reg : mode_hi_reg), mode_lo_reg, filter_reg,
        ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg};
      `SP_IDX_BUFFER: rd_word[7:0] = rx_buf_reg;
      `SP_IDX_IRQ_STATUS: rd_word[2:0] = irq_status_reg;
      `SP_IDX_IRQ_MASK: rd_word[2:0] = irq_mask_reg;
      `SP_IDX_BAUD_RELOAD: rd_word[RELOAD_WIDTH-1:0] = reload_reg;
      default: rd_word = 32'h0000_0000;
    endcase
    if (!addr_ok) begin
      rd_word = 32'h0000_0000;
    end
  end

  // multiprocessor filter and ninth-bit source at the stop sample
  always @* begin
    rx_ninth_val = mode[1] ? rx_ninth_tmp_reg : rx_sync_reg;
    rx_keep = 1'b1;
    if (filter_reg && mode[1] && !rx_ninth_tmp_reg) begin
      rx_keep = 1'b0;
    end
    if (filter_reg && (mode == 2'b01) && !rx_sync_reg) begin
      rx_keep = 1'b0;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
      irq_reg <= 1'b0;
    end else begin
      rx_meta_reg <= rxd_i;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_reg <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 10'h3FF;
      {mode_hi_reg, mode_lo_reg, filter_reg, ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg} <= `SP_RST_CTRL_STATUS;
      fe_reg <= 1'b0;
      {baud_double_reg, fcs_reg} <= PC_RESET[7:6];
      gflags_reg <= 2'b00;
      irq_status_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      reload_reg <= `SP_RST_BAUD_RELOAD;
      presc_cnt_reg <= 4'h0;
      tx_state_reg <= T_IDLE;
      tx_sub_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_phase_reg <= 1'b0;
      tx_shift_reg <= 8'h00;
      tx_ninth_reg <= 1'b0;
      txd_reg <= 1'b1;
      rxd_out_reg <= 1'b1;
      rxd_oe_reg <= 1'b0;
      rx_state_reg <= R_IDLE;
      rx_sub_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_phase_reg <= 1'b0;
      rx_shift_reg <= 8'h00;
      rx_ninth_tmp_reg <= 1'b0;
      rx_buf_reg <= 8'h00;
    end else begin
      wr_pend_reg <= bus_req && hwrite_i;
      wr_idx_reg <= addr_ok ? haddr_i[11:2] : 10'h3FF;
      if (bus_req && !hwrite_i) begin
        hrdata_reg <= rd_word;
      end
      if (wr_pend_reg) begin
        case (wr_idx_reg)
          `SP_IDX_POWER_CTRL: begin
            baud_double_reg <= hwdata_i[`SP_PC_BAUD_DOUBLE];
            fcs_reg <= hwdata_i[`SP_PC_FRAMING_CHECK];
            gflags_reg <= hwdata_i[`SP_PC_GFLAG_HI:`SP_PC_GFLAG_LO];
          end
          `SP_IDX_CTRL_STATUS: begin
            if (fcs_reg) begin
              fe_reg <= hwdata_i[`SP_SC_MODE_HI];
            end else begin
              mode_hi_reg <= hwdata_i[`SP_SC_MODE_HI];
            end
            mode_lo_reg <= hwdata_i[`SP_SC_MODE_LO];
            filter_reg <= hwdata_i[`SP_SC_FILTER];
            ren_reg <= hwdata_i[`SP_SC_RX_ENABLE];
            tb8_reg <= hwdata_i[`SP_SC_TX_NINTH];
            rb8_reg <= hwdata_i[`SP_SC_RX_NINTH];
            ti_reg <= hwdata_i[`SP_SC_TX_DONE];
            ri_reg <= hwdata_i[`SP_SC_RX_DONE];
          end
          `SP_IDX_BUFFER: begin
            // a write while a frame is shifting is dropped
            if (tx_idle && (rx_state_reg != R_SHIFT0)) begin
              tx_shift_reg <= hwdata_i[7:0];
              tx_ninth_reg <= tb8_reg;
              tx_sub_reg <= 4'h0;
              tx_bit_reg <= 3'h0;
              tx_phase_reg <= 1'b0;
              if (mode == 2'b00) begin
                tx_state_reg <= T_SHIFT0;
              end else begin
                tx_state_reg <= T_START;
                txd_reg <= 1'b0;
              end
            end
          end
          `SP_IDX_IRQ_STATUS: irq_status_reg <= irq_status_reg & ~hwdata_i[2:0];
          `SP_IDX_IRQ_MASK: irq_mask_reg <= hwdata_i[2:0];
          `SP_IDX_BAUD_RELOAD: reload_reg <= hwdata_i[RELOAD_WIDTH-1:0];
          default: ;
        endcase
      end

      if (adv) begin
        presc_cnt_reg <= tick ? 4'h0 : presc_cnt_reg + 4'h1;
      end

      // transmit shifter; flag sets come after the bus write so they win
      if (tick) begin
        case (tx_state_reg)
          T_START: begin
            tx_sub_reg <= tx_sub_reg + 4'h1;
            if (tx_sub_reg == `SP_SUB_LAST) begin
              txd_reg <= tx_shift_reg[0];
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
              tx_bit_reg <= 3'h0;
              tx_state_reg <= T_DATA;
            end
          end
          T_DATA: begin
            tx_sub_reg <= tx_sub_reg + 4'h1;
            if (tx_sub_reg == `SP_SUB_LAST) begin
              if (tx_bit_reg != 3'h7) begin
                txd_reg <= tx_shift_reg[0];
                tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                tx_bit_reg <= tx_bit_reg + 3'h1;
              end else if (mode[1]) begin
                txd_reg <= tx_ninth_reg;
                tx_state_reg <= T_NINTH;
              end else begin
                txd_reg <= 1'b1;
                tx_state_reg <= T_STOP;
                ti_reg <= 1'b1;
                irq_status_reg[`SP_IRQ_TX] <= 1'b1;
              end
            end
          end
          T_NINTH: begin
            tx_sub_reg <= tx_sub_reg + 4'h1;
            if (tx_sub_reg == `SP_SUB_LAST) begin
              txd_reg <= 1'b1;
              tx_state_reg <= T_STOP;
              ti_reg <= 1'b1;
              irq_status_reg[`SP_IRQ_TX] <= 1'b1;
            end
          end
          T_STOP: begin
            tx_sub_reg <= tx_sub_reg + 4'h1;
            if (tx_sub_reg == `SP_SUB_LAST) begin
              tx_state_reg <= T_IDLE;
            end
          end
          T_SHIFT0: begin
            tx_phase_reg <= ~tx_phase_reg;
            if (!tx_phase_reg) begin
              txd_reg <= 1'b0;
              rxd_out_reg <= tx_shift_reg[0];
              rxd_oe_reg <= 1'b1;
            end else begin
              txd_reg <= 1'b1;
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
              tx_bit_reg <= tx_bit_reg + 3'h1;
              if (tx_bit_reg == 3'h7) begin
                tx_state_reg <= T_IDLE;
                rxd_oe_reg <= 1'b0;
                rxd_out_reg <= 1'b1;
                ti_reg <= 1'b1;
                irq_status_reg[`SP_IRQ_TX] <= 1'b1;
              end
            end
          end
          default: ;
        endcase
      end

      // receive shifter
      if (!ren_reg) begin
        rx_state_reg <= R_IDLE;
      end else begin
        case (rx_state_reg)
          R_IDLE: begin
            rx_sub_reg <= 4'h0;
            rx_bit_reg <= 4'h0;
            rx_phase_reg <= 1'b0;
            if ((mode != 2'b00) && rx_prev_reg && !rx_sync_reg) begin
              rx_state_reg <= R_START;
            end else if ((mode == 2'b00) && !ri_reg && tx_idle && !wr_pend_reg) begin
              rx_state_reg <= R_SHIFT0;
            end
          end
          R_START: begin
            if (tick) begin
              rx_sub_reg <= rx_sub_reg + 4'h1;
              if ((rx_sub_reg == `SP_SUB_MID) && rx_sync_reg) begin
                rx_state_reg <= R_IDLE;
              end else if (rx_sub_reg == `SP_SUB_LAST) begin
                rx_state_reg <= R_DATA;
              end
            end
          end
          R_DATA: begin
            if (tick) begin
              rx_sub_reg <= rx_sub_reg + 4'h1;
              if (rx_sub_reg == `SP_SUB_MID) begin
                if (rx_bit_reg[3]) begin
                  rx_ninth_tmp_reg <= rx_sync_reg;
                end else begin
                  rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]};
                end
              end
              if (rx_sub_reg == `SP_SUB_LAST) begin
                if (rx_bit_reg == (mode[1] ? 4'h8 : 4'h7)) begin
                  rx_state_reg <= R_STOP;
                end else begin
                  rx_bit_reg <= rx_bit_reg + 4'h1;
                end
              end
            end
          end
          R_STOP: begin
            if (tick) begin
              rx_sub_reg <= rx_sub_reg + 4'h1;
              if (rx_sub_reg == `SP_SUB_MID) begin
                rx_state_reg <= R_IDLE;
                if (rx_keep) begin
                  rx_buf_reg <= rx_shift_reg;
                  rb8_reg <= rx_ninth_val;
                  ri_reg <= 1'b1;
                  irq_status_reg[`SP_IRQ_RX] <= 1'b1;
                end
                if (!rx_sync_reg) begin
                  fe_reg <= 1'b1;
                  irq_status_reg[`SP_IRQ_FE] <= 1'b1;
                end
              end
            end
          end
          R_SHIFT0: begin
            if (tick) begin
              rx_phase_reg <= ~rx_phase_reg;
              if (!rx_phase_reg) begin
                txd_reg <= 1'b0;
              end else begin
                txd_reg <= 1'b1;
                rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]};
                rx_bit_reg <= rx_bit_reg + 4'h1;
                if (rx_bit_reg == 4'h7) begin
                  rx_state_reg <= R_IDLE;
                  rx_buf_reg <= {rx_sync_reg, rx_shift_reg[7:1]};
                  ri_reg <= 1'b1;
                  irq_status_reg[`SP_IRQ_RX] <= 1'b1;
                end
              end
            end
          end
          default: rx_state_reg <= R_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/serial_port0_defs.vh ***
// Purpose: constants of the first serial port control block
// Assumes: registers sit behind an AHB-Lite slave, one aligned word each
// Notes: byte address is four times the register index
// Behaviour
// - control bit 7 is upper mode bit or framing error flag, chosen by power control
// - framing error flag sets for a bad stop bit; only software clears it
// - mode bits pick sync 8-bit, async 10-bit variable, async 11-bit fixed, async 11-bit variable
// - modes 2 and 3 with filter set: no receive-done when ninth bit is zero
// - mode 1 with filter set: no receive-done without a valid stop bit
// - mode 0 filter bit picks shift clock: oscillator over 12 or over 4
// - frames are accepted only while receive enable is one
// - modes 2 and 3 send the software ninth bit as ninth data bit
// - received ninth bit holds ninth data bit, mode 1 stop bit, nothing in mode 0
// - transmit-done sets after 8th bit in mode 0, at stop start otherwise
// - receive-done sets after 8th bit in mode 0, mid stop otherwise, filtered
// - framing check select one makes bit 7 the framing error flag
// - baud double bit doubles the bit rate in modes 1, 2 and 3
// - buffer address reads receive buffer and writes transmit buffer
`ifndef SERIAL_PORT0_DEFS_VH
`define SERIAL_PORT0_DEFS_VH

`define SP_IDX_POWER_CTRL 10'h087
`define SP_IDX_CTRL_STATUS 10'h098
`define SP_IDX_BUFFER 10'h099
`define SP_IDX_IRQ_STATUS 10'h0C0
`define SP_IDX_IRQ_MASK 10'h0C1
`define SP_IDX_BAUD_RELOAD 10'h0C2

`define SP_PC_BAUD_DOUBLE 7
`define SP_PC_FRAMING_CHECK 6
`define SP_PC_GFLAG_HI 3
`define SP_PC_GFLAG_LO 2

`define SP_SC_MODE_HI 7
`define SP_SC_MODE_LO 6
`define SP_SC_FILTER 5
`define SP_SC_RX_ENABLE 4
`define SP_SC_TX_NINTH 3
`define SP_SC_RX_NINTH 2
`define SP_SC_TX_DONE 1
`define SP_SC_RX_DONE 0

`define SP_IRQ_TX 0
`define SP_IRQ_RX 1
`define SP_IRQ_FE 2

`define SP_RST_CTRL_STATUS 8'h00
`define SP_RST_POWER_CTRL 8'h00
`define SP_RST_BAUD_RELOAD 16'h0000

`define SP_M0_HALF_SLOW 4'h6
`define SP_M0_HALF_FAST 4'h2
`define SP_M2_SUB_SLOW 4'h4
`define SP_M2_SUB_FAST 4'h2
`define SP_VAR_SUB_SLOW 4'h2
`define SP_VAR_SUB_FAST 4'h1
`define SP_SUB_MID 4'h7
`define SP_SUB_LAST 4'hF

`endif

// *** hdl/baud_timer.v ***
// Purpose: reload counter whose overflow paces the variable-rate modes
// Assumes: counts up every clock from the reload value to all ones
// Notes: overflow period is 2^WIDTH minus reload clocks
`default_nettype none
module baud_timer #(
  parameter WIDTH = 16
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [WIDTH-1:0] reload_i,
  output wire ovf_o
);
  reg [WIDTH-1:0] cnt_reg;
  reg ovf_reg;

  assign ovf_o = ovf_reg;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= {WIDTH{1'b0}};
      ovf_reg <= 1'b0;
    end else if (cnt_reg == {WIDTH{1'b1}}) begin
      cnt_reg <= reload_i;
      ovf_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      ovf_reg <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** bench/serial_peer_model.sv ***
// Purpose: remote serial peer on the receive and transmit pins
// Assumes: bit time in clocks is handed in with each async frame
// Notes: the peer line idles high, as a pulled-up pin does
`default_nettype none
module serial_peer_model (
  input wire logic sys_clk_i,
  input wire logic txd_i,
  input wire logic dat_i,
  input wire logic oe_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // set when a wait for the block runs out
  logic late = 1'b0;
  initial line_o = 1'b1;
  task automatic send(input logic [8:0] d, input logic nine, input logic stop, input int bit_len);
    logic [10:0] f;
    f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    for (int i = 0; i < 10 + nine; i++) begin
      line_o <= f[i];
      repeat (bit_len) @(posedge sys_clk_i);
    end
    line_o <= 1'b1;
  endtask
  // samples each bit in its middle, returns at mid stop
  task automatic rx_frame(input int bit_len, input logic nine, output logic [8:0] d, output logic stop);
    int n;
    n = 0;
    d = 9'h000;
    while (txd_i !== 1'b0 && n < 20000) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (txd_i !== 1'b0) late = 1'b1;
    repeat (bit_len / 2) @(posedge sys_clk_i);
    for (int i = 0; i < 8 + nine; i++) begin
      repeat (bit_len) @(posedge sys_clk_i);
      d[i] = txd_i;
    end
    repeat (bit_len) @(posedge sys_clk_i);
    stop = txd_i;
  endtask
  // shift clock is txd, data taken on its rising edge
  task automatic m0_frame(output logic [7:0] d);
    int n;
    int i;
    logic p;
    logic v;
    n = 0;
    i = 0;
    p = 1'b1;
    v = 1'b1;
    d = 8'h00;
    while (i < 8 && n < 5000) begin
      @(posedge sys_clk_i);
      n++;
      // data stands through the low half; the last bit releases the pin as the clock rises
      if (txd_i === 1'b1 && p === 1'b0) begin
        d[i] = v;
        i++;
      end
      if (oe_i === 1'b1 && txd_i === 1'b0) v = dat_i;
      p = txd_i;
    end
    if (i < 8) late = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** bench/serial_port0_checker.sv ***
// Purpose: port-level checks of the first serial port block
// Assumes: control word shadowed from bus writes
// Notes: bound into every instance of the block
`default_nettype none
module serial_port0_checker (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire hready_i,
  input wire [31:0] hwdata_i,
  input wire [31:0] hrdata_o,
  input wire hreadyout_o,
  input wire hresp_o,
  input wire rxd_o,
  input wire rxd_oe_o,
  input wire txd_o,
  input wire irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_q;
  logic [31:0] a_q;
  logic [7:0] cs_q;
  logic [3:0] falls;
  wire take = hsel_i & hready_i & htrans_i[1];
  wire m0 = cs_q[7:6] == 2'b00;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= 1'b0;
      a_q <= 32'h0000_0000;
      cs_q <= 8'h00;
      falls <= 4'h0;
    end else begin
      wr_q <= take & hwrite_i;
      a_q <= take ? haddr_i : a_q;
      if (wr_q && a_q == 32'h0000_0260) cs_q <= hwdata_i[7:0];
      if (!rxd_oe_o) falls <= 4'h0;
      else if ($fell(txd_o)) falls <= falls + 4'h1;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence half_fast;
    !txd_o ##1 txd_o;
  endsequence
  sequence half_slow;
    !txd_o [*5] ##1 txd_o;
  endsequence
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus not ready or not okay");
  oe_mode_a: assert property (rxd_oe_o |-> m0)
    else $error("data pin driven outside mode 0");
  m0_fast_a: assert property (m0 && cs_q[5] && $fell(txd_o) |-> ##1 half_fast)
    else $error("fast shift clock half not 2 clocks");
  m0_slow_a: assert property (m0 && !cs_q[5] && $fell(txd_o) |-> ##1 half_slow)
    else $error("slow shift clock half not 6 clocks");
  m0_bits_a: assert property ($fell(rxd_oe_o) |-> falls == 4'h8)
    else $error("mode 0 frame not 8 bits");
  irq_mask_a: assert property (wr_q && a_q == 32'h0000_0304 && hwdata_i[2:0] == 3'b000 |-> ##2 !irq_o)
    else $error("irq stays up after mask cleared");
  unmapped_a: assert property (take && !hwrite_i && haddr_i == 32'h0000_0FFC |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (take && !hwrite_i |=> hrdata_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
endmodule
bind serial_port0_control serial_port0_checker u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hwdata_i(hwdata_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o),
  .txd_o(txd_o), .irq_o(irq_o));
`default_nettype wire

// *** bench/serial_port0_control_tb_top.sv ***
// Purpose: self-checking bench of the first serial port block
// Assumes: zero-wait bus slave, peer line idles high
// Notes: reload near all ones keeps variable-rate frames short
`include "serial_port0_defs.vh"
`default_nettype none
module serial_port0_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] i_pc = `SP_IDX_POWER_CTRL;
  localparam logic [9:0] i_cs = `SP_IDX_CTRL_STATUS;
  localparam logic [9:0] i_buf = `SP_IDX_BUFFER;
  localparam logic [9:0] i_ist = `SP_IDX_IRQ_STATUS;
  localparam logic [9:0] i_msk = `SP_IDX_IRQ_MASK;
  localparam logic [9:0] i_rld = `SP_IDX_BAUD_RELOAD;
  logic sys_clk, rst_n, hwrite, hreadyout, hresp, rxd_w, rxd_o, rxd_oe, txd, irq, peer_line;
  logic stop, bd, ren, filt, ok, fe;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [8:0] d, got;
  logic [7:0] b;
  int errors, compares, k, m, f;
  serial_port0_control #(.RELOAD_WIDTH(16)) u_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hready_i(hreadyout),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .rxd_i(rxd_w),
    .rxd_o(rxd_o), .rxd_oe_o(rxd_oe), .txd_o(txd), .irq_o(irq));
  serial_peer_model u_peer (.sys_clk_i(sys_clk), .txd_i(txd), .dat_i(rxd_o), .oe_i(rxd_oe), .line_o(peer_line));
  assign rxd_w = rxd_oe ? rxd_o : peer_line;
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic int bit_len(input int md, input logic dbl);
    return (md == 2 ? 64 : 128) >> dbl;
  endfunction
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic peer_late;
    if (u_peer.late) begin
      errors++;
      wrap_up;
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      wrap_up;
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    haddr <= {20'h0_0000, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy;
    q = hrdata;
  endtask
  initial begin
    rst_n = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    errors = 0;
    compares = 0;
    fe = 1'b0;
    void'($urandom(49));
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(0, i_cs, 0);
    check("ctrl reset", q, 32'h0000_0000);
    bus(0, i_pc, 0);
    check("pwr reset", q, 32'h0000_0000);
    bus(1, 10'h3FF, 32'hFFFF_FFFF);
    bus(0, 10'h3FF, 0);
    check("unmapped", q, 32'h0000_0000);
    repeat (4) begin
      d = $urandom;
      bus(1, i_pc, {24'h00_0000, d[7:0] & 8'hCC});
      bus(1, i_cs, {24'h00_0000, d[7:0] & 8'hEF});
      bus(0, i_pc, 0);
      check("pwr rw", q, {24'h00_0000, d[7:0] & 8'hCC});
      bus(0, i_cs, 0);
      check("ctrl rw", q, {24'h00_0000, d[7:0] & 8'hEF});
    end
    // clear a framing flag left by the random writes, then the mode bit
    bus(1, i_pc, 32'h0000_0040);
    bus(1, i_cs, 0);
    bus(1, i_pc, 0);
    bus(1, i_cs, 0);
    bus(1, i_rld, 32'h0000_FFFC);
    bus(1, i_msk, 32'h0000_0007);
    bus(1, i_ist, 32'h0000_0007);
    // the timer runs a full count from reset before the new reload applies
    repeat (65536) @(posedge sys_clk);
    for (m = 1; m < 4; m++) begin
      bd = $urandom;
      d = $urandom;
      bus(1, i_pc, {24'h00_0000, bd, 7'h00});
      bus(1, i_cs, {24'h00_0000, m[1:0], 2'b00, d[8], 3'b000});
      // second write lands while busy and must be dropped
      fork
        u_peer.rx_frame(bit_len(m, bd), m != 1, got, stop);
        begin
          bus(1, i_buf, {24'h00_0000, d[7:0]});
          bus(1, i_buf, {24'h00_0000, ~d[7:0]});
        end
      join
      peer_late;
      check("tx data", got, m == 1 ? {1'b0, d[7:0]} : d);
      check("tx stop", stop, 1'b1);
      check("tx irq", irq, 1'b1);
      bus(1, i_msk, 0);
      repeat (2) @(posedge sys_clk);
      check("irq masked", irq, 1'b0);
      bus(1, i_msk, 32'h0000_0007);
      bus(0, i_cs, 0);
      check("tx done", q[1], 1'b1);
      check("irq back", irq, 1'b1);
      bus(1, i_ist, 32'h0000_0001);
      bus(1, i_cs, 0);
      check("irq clear", irq, 1'b0);
      k = 0;
      repeat (bit_len(m, bd) * 12) begin
        @(posedge sys_clk);
        k += (txd !== 1'b1);
      end
      check("no resend", k, 0);
    end
    bus(1, i_pc, 0);
    for (f = 0; f < 2; f++) begin
      d = $urandom;
      bus(1, i_cs, {26'h000_0000, f[0], 5'h00});
      fork
        u_peer.m0_frame(b);
        bus(1, i_buf, {24'h00_0000, d[7:0]});
      join
      peer_late;
      repeat (8) @(posedge sys_clk);
      check("m0 data", b, d[7:0]);
      bus(0, i_cs, 0);
      check("m0 done", q[1], 1'b1);
    end
    // mode 0 receive with the pin idle high shifts in all ones
    bus(1, i_cs, 32'h0000_0030);
    repeat (60) @(posedge sys_clk);
    bus(0, i_buf, 0);
    check("m0 rx data", q, 32'h0000_00FF);
    bus(0, i_cs, 0);
    check("m0 rx done", q[0], 1'b1);
    for (k = 0; k < 14; k++) begin
      m = 1 + k % 3;
      d = $urandom;
      d[8] = (k >= 6);
      ren = (k < 12);
      filt = (k % 6) >= 3;
      stop = m == 1 ? d[8] : 1'b1;
      bus(1, i_pc, 0);
      bus(1, i_cs, {24'h00_0000, m[1:0], filt, ren, 4'h0});
      bus(1, i_pc, 32'h0000_0040);
      bus(1, i_ist, 32'h0000_0007);
      u_peer.send(d, m != 1, stop, bit_len(m, 1'b0));
      repeat (4) @(posedge sys_clk);
      fe = fe | (ren & !stop);
      ok = ren & (!filt | d[8]);
      bus(0, i_cs, 0);
      check("fe", q[7], fe);
      check("rx done", q[0], ok);
      check("rx irq", irq, ok | (ren & !stop));
      if (ok && (m != 1 || !filt)) begin
        check("rx ninth", q[2], d[8]);
        bus(0, i_buf, 0);
        check("rx data", q, {24'h00_0000, d[7:0]});
      end
    end
    bus(1, i_cs, 0);
    bus(0, i_cs, 0);
    check("fe clear", q[7], 1'b0);
    bus(1, i_pc, 0);
    wrap_up;
  end
endmodule
`default_nettype wire
